// file: design/dlt_pkg.sv
// Package holding constants and types of the delay timer block.
package dlt_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [11:0] DLT_CTRL_OFS = 12'h000;
   localparam logic [11:0] DLT_ON_INIT_OFS = 12'h004;
   localparam logic [11:0] DLT_OFF_INIT_OFS = 12'h008;
   localparam logic [11:0] DLT_STATUS_OFS = 12'h00C;
   localparam logic [11:0] DLT_TICKDIV_OFS = 12'h010;

   // ---------------------------------------------------------------
   // Control field positions and reset values
   // ---------------------------------------------------------------
   localparam int DLT_CTRL_MODE_LSB = 0;
   localparam int DLT_CTRL_UNIT_LSB = 2;
   localparam int DLT_CTRL_ON_SEL_BIT = 4;
   localparam int DLT_CTRL_OFF_SEL_BIT = 5;
   localparam logic [5:0] DLT_CTRL_RESET = 6'h00;
   localparam logic [15:0] DLT_INIT_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // Time base: 40 MHz clock, 1 ms base tick
   // ---------------------------------------------------------------
   localparam int DLT_CLK_HZ = 40000000;
   localparam int DLT_MS_PER_S = 1000;
   localparam int DLT_MS_CYCLES = DLT_CLK_HZ / DLT_MS_PER_S;
   localparam logic [31:0] DLT_S_MS = 32'd1000;
   localparam logic [31:0] DLT_MIN_MS = 32'd60000;
   localparam logic [31:0] DLT_HOUR_MS = 32'd3600000;

   typedef enum logic [1:0] {
      DLT_MODE_ONOFF,
      DLT_MODE_RETAIN,
      DLT_MODE_OFFDLY,
      DLT_MODE_RELAY
   } dlt_mode_e;

   typedef enum logic [1:0] {
      DLT_UNIT_MS,
      DLT_UNIT_S,
      DLT_UNIT_MIN,
      DLT_UNIT_HOUR
   } dlt_unit_e;

endpackage : dlt_pkg

// file: design/dlt_tick_gen.sv
// Unit tick strobe generator for the delay timer.
`timescale 1ns/1ps
`default_nettype none
module dlt_tick_gen
   import dlt_pkg::*;
#(
   parameter int MS_CYCLES = DLT_MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic restart,
   input wire dlt_pkg::dlt_unit_e unit,
   output logic tick
);
   // -------------------------------------------------------------
   // Millisecond prescaler and unit divider
   // -------------------------------------------------------------
   logic [31:0] pre_q;
   logic [31:0] ms_q;
   logic [31:0] ms_lim;
   logic ms_tick;

   // Unit selection picks how many milliseconds make one time unit.
   always_comb begin
      case (unit)
         DLT_UNIT_MS: ms_lim = 32'd1;
         DLT_UNIT_S: ms_lim = DLT_S_MS;
         DLT_UNIT_MIN: ms_lim = DLT_MIN_MS;
         DLT_UNIT_HOUR: ms_lim = DLT_HOUR_MS;
         default: ms_lim = 32'd1;
      endcase
   end

   assign ms_tick = (pre_q == 32'(MS_CYCLES - 1));

   // Restart aligns the unit grid with a trigger change so delays are exact.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 32'h0000_0000;
      end else if (restart || ms_tick) begin
         pre_q <= 32'h0000_0000;
      end else begin
         pre_q <= pre_q + 32'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_q <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (restart) begin
         ms_q <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (ms_tick) begin
         if (ms_q + 32'd1 >= ms_lim) begin
            ms_q <= 32'h0000_0000;
            tick <= 1'b1;
         end else begin
            ms_q <= ms_q + 32'd1;
            tick <= 1'b0;
         end
      end else begin
         tick <= 1'b0;
      end
   end
endmodule : dlt_tick_gen
`default_nettype wire

// file: design/dlt_apb_regs.sv
// APB register file of the delay timer.
`timescale 1ns/1ps
`default_nettype none
module dlt_apb_regs
   import dlt_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [1:0] status,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [5:0] ctrl_q,
   output logic [15:0] on_init_q,
   output logic [15:0] off_init_q
);
   // -------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = (paddr == DLT_CTRL_OFS) || (paddr == DLT_ON_INIT_OFS) ||
                   (paddr == DLT_OFF_INIT_OFS) || (paddr == DLT_STATUS_OFS);

   // Writes land in the access phase; status is read only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= DLT_CTRL_RESET;
         on_init_q <= DLT_INIT_RESET;
         off_init_q <= DLT_INIT_RESET;
      end else if (acc && pwrite) begin
         if (paddr == DLT_CTRL_OFS) begin
            ctrl_q <= pwdata[5:0];
         end
         if (paddr == DLT_ON_INIT_OFS) begin
            on_init_q <= pwdata[15:0];
         end
         if (paddr == DLT_OFF_INIT_OFS) begin
            off_init_q <= pwdata[15:0];
         end
      end
   end

   // Zero wait states; unmapped addresses answer with an error and zero data.
   always_comb begin
      pready = 1'b1;
      pslverr = acc && !mapped;
      prdata = 32'h0000_0000;
      if (acc && !pwrite) begin
         case (paddr)
            DLT_CTRL_OFS: prdata = {26'h0, ctrl_q};
            DLT_ON_INIT_OFS: prdata = {16'h0, on_init_q};
            DLT_OFF_INIT_OFS: prdata = {16'h0, off_init_q};
            DLT_STATUS_OFS: prdata = {30'h0, status};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule : dlt_apb_regs
`default_nettype wire

// file: design/dlt_timer.sv
// Top of the on/off, retentive, off-delay and relay-pulse timer.
// ----------------------------------------------------------------
// Summary of operation
// - On/off mode: trigger high for full on delay sets output high.
// - On/off mode: trigger low for full off delay clears output.
// - Shorter trigger excursions leave output unchanged and restart timing.
// - Each delay comes from stored setting or time input, 0-65535 units.
// - One unit selection (ms, s, min, h) for both delays, default ms.
// - Connected time inputs replace the stored initial values.
// - Retentive mode holds output high after delay even when trigger drops.
// - Rising clear edge forces retentive output low and restarts timing.
// - Retentive delay from stored setting or input, 0-65535 units.
// - Off-delay of 3 s drops output 3 s after fall, rises at once.
// - Relay mode takes trigger and time input overriding stored duration.
// - Relay output rises with trigger, holds for duration, drops early on low.
// - Off-delay output follows rise at once, falls after full off delay.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dlt_timer
   import dlt_pkg::*;
#(
   parameter int MS_CYCLES = DLT_MS_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger,
   input wire logic clear_in,
   input wire logic [15:0] rise_delay_value,
   input wire logic [15:0] fall_delay_value,
   output logic timer_output
);
   import dlt_pkg::*;

   // ---------------------------------------------------------------
   // Registers and configuration
   // ---------------------------------------------------------------
   logic [5:0] ctrl_q;
   logic [15:0] on_init_q;
   logic [15:0] off_init_q;
   logic [31:0] prdata_c;
   logic pready_c;
   logic pslverr_c;
   logic [1:0] status;
   dlt_mode_e mode;
   dlt_unit_e unit;
   logic [15:0] on_dly;
   logic [15:0] off_dly;

   dlt_apb_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .status(status),
      .prdata(prdata_c),
      .pready(pready_c),
      .pslverr(pslverr_c),
      .ctrl_q(ctrl_q),
      .on_init_q(on_init_q),
      .off_init_q(off_init_q)
   );

   // Bus answers are passed straight through; the slave is zero-wait.
   // A registered read path would cost a wait state on every access,
   // so these three are the only outputs not taken from a flip-flop.
   assign prdata = prdata_c;
   assign pready = pready_c;
   assign pslverr = pslverr_c;

   assign mode = dlt_mode_e'(ctrl_q[DLT_CTRL_MODE_LSB +: 2]);
   assign unit = dlt_unit_e'(ctrl_q[DLT_CTRL_UNIT_LSB +: 2]);

   // Select bits model a connected time input; it replaces the stored value.
   assign on_dly = ctrl_q[DLT_CTRL_ON_SEL_BIT] ? rise_delay_value : on_init_q;
   assign off_dly = ctrl_q[DLT_CTRL_OFF_SEL_BIT] ? fall_delay_value : off_init_q;

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   logic trig_q;
   logic clr_q;
   logic mode_chg;
   logic [1:0] mode_q;
   logic trig_edge;
   logic clr_rise;

   // Detectors reset to the idle low level of their inputs, so a
   // release of reset with the inputs low never shows a false edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q <= 1'b0;
         clr_q <= 1'b0;
         mode_q <= 2'h0;
      end else begin
         trig_q <= trigger;
         clr_q <= clear_in;
         mode_q <= ctrl_q[DLT_CTRL_MODE_LSB +: 2];
      end
   end

   assign trig_edge = trigger ^ trig_q;
   assign clr_rise = clear_in && !clr_q;
   assign mode_chg = mode_q != ctrl_q[DLT_CTRL_MODE_LSB +: 2];

   // ---------------------------------------------------------------
   // Unit tick
   // ---------------------------------------------------------------
   logic tick;
   logic restart;

   // Any trigger edge restarts the unit grid so each delay is measured from it.
   assign restart = trig_edge || clr_rise || mode_chg;

   dlt_tick_gen #(
      .MS_CYCLES(MS_CYCLES)
   ) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .restart(restart),
      .unit(unit),
      .tick(tick)
   );

   // ---------------------------------------------------------------
   // Elapsed counter
   // ---------------------------------------------------------------
   logic [16:0] elapsed_q;
   logic [15:0] target;
   logic done;

   // Count saturates above the largest delay so it never wraps.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed_q <= 17'h00000;
      end else if (restart) begin
         elapsed_q <= 17'h00000;
      end else if (tick && !elapsed_q[16]) begin
         elapsed_q <= elapsed_q + 17'h00001;
      end
   end

   // In on/off mode the delay that applies is the one for the level the trigger now holds; other modes use one fixed delay.
   always_comb begin
      case (mode)
         DLT_MODE_ONOFF: target = trig_q ? on_dly : off_dly;
         DLT_MODE_OFFDLY: target = off_dly;
         DLT_MODE_RETAIN: target = on_dly;
         DLT_MODE_RELAY: target = on_dly;
         default: target = on_dly;
      endcase
   end

   // Zero delay compares true at once, with no tick needed.
   assign done = !restart && (elapsed_q >= {1'b0, target});

   // ---------------------------------------------------------------
   // Output state
   // ---------------------------------------------------------------
   // Limits that a user must know:
   // A change of time unit alone does not restart timing.
   // The next trigger edge or mode change realigns the grid.
   // Time inputs are read every cycle and act at once,
   // even in the middle of a running delay.
   // The elapsed count saturates, so it never wraps.
   // The clear input acts on its rising edge only.
   logic out_q;
   logic latched_q;
   logic relay_q;

   // Relay pulse: armed by a rising trigger, ended by timeout or trigger low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relay_q <= 1'b0;
      end else if (trigger && !trig_q) begin
         relay_q <= 1'b1;
      end else if (!trigger || done) begin
         relay_q <= 1'b0;
      end
   end

   // Retentive latch; the clear edge wins over a delay completing.
   // Only the retentive mode sets it, so entering that mode starts low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_q <= 1'b0;
      end else if (clr_rise || mode_chg) begin
         latched_q <= 1'b0;
      end else if (mode == DLT_MODE_RETAIN && trig_q && trigger && done) begin
         latched_q <= 1'b1;
      end
   end

   // Output register per mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 1'b0;
      end else begin
         case (mode)
            DLT_MODE_ONOFF: begin
               if (done && trig_q == trigger) begin
                  out_q <= trig_q;
               end
            end
            DLT_MODE_OFFDLY: begin
               if (trigger) begin
                  out_q <= 1'b1;
               end else if (!trig_q && done) begin
                  out_q <= 1'b0;
               end
            end
            DLT_MODE_RETAIN: begin
               // Entering this mode drops any level left by the last one.
               if (clr_rise || mode_chg) begin
                  out_q <= 1'b0;
               end else begin
                  out_q <= latched_q || (trig_q && trigger && done);
               end
            end
            DLT_MODE_RELAY: begin
               out_q <= trigger && ((trigger && !trig_q) || (relay_q && !done));
            end
            default: out_q <= 1'b0;
         endcase
      end
   end

   assign timer_output = out_q;
   assign status = {latched_q, out_q};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Every property runs on the bus clock and is muted in reset.
   // Antecedents of the mode checks name the mode, so a mode change never trips a check.
   a_onoff_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_ONOFF && !mode_chg && trig_q && trigger && done && !out_q) |=> out_q)
      else $error("On/off output did not rise after on delay.");

   a_onoff_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_ONOFF && !mode_chg && !trig_q && !trigger && done && out_q) |=> !out_q)
      else $error("On/off output did not fall after off delay.");

   a_onoff_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_ONOFF && $past(mode == DLT_MODE_ONOFF) && !$past(done)) |-> $stable(out_q))
      else $error("On/off output changed before delay elapsed.");

   a_restart_clr: assert property (@(posedge pclk) disable iff (!presetn)
      restart |=> elapsed_q == 17'h00000)
      else $error("Elapsed count not restarted.");

   a_retain_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RETAIN && out_q && !clr_rise && !mode_chg) |=> out_q)
      else $error("Retentive output dropped without clear edge.");

   a_retain_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RETAIN && clr_rise) |=> !out_q && !latched_q)
      else $error("Clear edge did not drop retentive output.");

   a_offdly_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_OFFDLY && trigger) |=> out_q)
      else $error("Off-delay output did not follow rising trigger.");

   a_relay_low: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RELAY && !trigger) |=> !out_q)
      else $error("Relay output stayed high with trigger low.");

   a_tick_count: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !restart && !elapsed_q[16]) |=> elapsed_q == $past(elapsed_q) + 17'h00001)
      else $error("Elapsed count did not advance on tick.");

   a_src_select: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[DLT_CTRL_ON_SEL_BIT] |-> on_dly == rise_delay_value)
      else $error("Time input did not replace stored on delay.");

   // Low time over drops the off-delay output.
   a_offdly_fall: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_OFFDLY && !trig_q && !trigger && done) |=> !out_q)
      else $error("Off-delay output did not fall.");

   // A rising trigger raises the relay output.
   a_relay_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RELAY && trigger && !trig_q) |=> out_q)
      else $error("Relay output did not rise.");

   // The pulse holds while its time runs.
   a_relay_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RELAY && relay_q && trig_q && trigger && !done) |=> out_q)
      else $error("Relay output dropped early.");

   // The pulse ends when its time is over.
   a_relay_expire: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RELAY && relay_q && trig_q && done) |=> !out_q)
      else $error("Relay output did not expire.");

   // The off-time input replaces the stored one.
   a_offsel_input: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[DLT_CTRL_OFF_SEL_BIT] |-> off_dly == fall_delay_value)
      else $error("Time input did not replace stored off delay.");

   // Output and latch set together.
   a_retain_set: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RETAIN && !clr_rise && !mode_chg && trig_q && trigger && done) |=> out_q && latched_q)
      else $error("Retentive output did not latch.");

   // A held clear level does not block a latch.
   a_clr_level: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_RETAIN && clr_q && clear_in && trig_q && trigger && done) |=> out_q)
      else $error("Clear level blocked the latch.");

   // The latch stays clear in other modes.
   a_latch_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (mode != DLT_MODE_RETAIN && !mode_chg) |-> !latched_q)
      else $error("Latch set outside retentive mode.");

   // A trigger edge never moves the on/off output.
   a_onoff_glitch: assert property (@(posedge pclk) disable iff (!presetn)
      (mode == DLT_MODE_ONOFF && trig_q != trigger) |=> $stable(out_q))
      else $error("On/off output followed a trigger edge.");

endmodule : dlt_timer
`default_nettype wire

// file: design/unused_placeholder_note.sv
// Intentionally empty compile unit kept minimal.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: bench/dlt_far_model.sv
// Model of the program blocks that feed the delay timer its trigger, clear and time inputs.
`timescale 1ns/1ps
`default_nettype none
module dlt_far_model (
   input wire logic pclk,
   output logic trigger,
   output logic clear_in,
   output logic [15:0] rise_delay_value,
   output logic [15:0] fall_delay_value
);
   // ---------------------------------------------------------------
   // Drive tasks
   // ---------------------------------------------------------------
   // Upstream logic settles its outputs once per program cycle, so every change lands just after an edge.
   initial begin
      trigger = 1'b0;
      clear_in = 1'b0;
      rise_delay_value = 16'h0000;
      fall_delay_value = 16'h0000;
   end

   task automatic set_trig(input logic v);
      @(posedge pclk);
      trigger <= v;
   endtask : set_trig

   task automatic set_clear(input logic v);
      @(posedge pclk);
      clear_in <= v;
   endtask : set_clear

   task automatic set_times(input logic [15:0] rise_v, input logic [15:0] fall_v);
      @(posedge pclk);
      rise_delay_value <= rise_v;
      fall_delay_value <= fall_v;
   endtask : set_times
endmodule : dlt_far_model
`default_nettype wire

// file: bench/dlt_timer_test.sv
// Self-checking testbench of the delay timer with an APB master and output timing checks.
`timescale 1ns/1ps
`default_nettype none
module dlt_timer_test;
   import dlt_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   // A short millisecond keeps each ms delay a few cycles long; one ms unit is four clocks.
   localparam int MSC = 4;
   logic pclk = 1'b0;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   wire logic trigger;
   wire logic clear_in;
   wire logic [15:0] rise_delay_value;
   wire logic [15:0] fall_delay_value;
   logic timer_output;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int check_count = 0;

   dlt_timer #(.MS_CYCLES(MSC)) dlt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trigger(trigger), .clear_in(clear_in), .rise_delay_value(rise_delay_value),
      .fall_delay_value(fall_delay_value), .timer_output(timer_output));

   dlt_far_model dlt_far_model_inst (.pclk(pclk), .trigger(trigger), .clear_in(clear_in),
      .rise_delay_value(rise_delay_value), .fall_delay_value(fall_delay_value));

   always #12.5 pclk = ~pclk;

   // ---------------------------------------------------------------
   // Helper tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is seen high, bounded by a limit.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "no pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h00000000);
      chk(rd, exp, "read data");
      chk({31'h0, err}, {31'h0, exp_err}, "read error flag");
   endtask : rd_chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic out_is(input logic exp, input string msg);
      chk({31'h0, timer_output}, {31'h0, exp}, msg);
   endtask : out_is

   task automatic trig(input logic v);
      dlt_far_model_inst.set_trig(v);
   endtask : trig

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   // The seconds test dominates at about 12000 cycles; everything else is a few hundred.
   initial begin
      repeat (40000) @(posedge pclk);
      failures++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Register reset values, width and unmapped access.
      rd_chk(DLT_CTRL_OFS, 32'h00000000, 1'b0);
      rd_chk(DLT_ON_INIT_OFS, 32'h00000000, 1'b0);
      rd_chk(DLT_OFF_INIT_OFS, 32'h00000000, 1'b0);
      rd_chk(DLT_STATUS_OFS, 32'h00000000, 1'b0);
      rd_chk(DLT_TICKDIV_OFS, 32'h00000000, 1'b1);
      apb(1'b1, DLT_ON_INIT_OFS, 32'hFFFFFFFF);
      rd_chk(DLT_ON_INIT_OFS, 32'h0000FFFF, 1'b0);
      for (int u = 0; u < 4; u++) begin
         apb(1'b1, DLT_CTRL_OFS, 32'(u) << 2);
         rd_chk(DLT_CTRL_OFS, 32'(u) << 2, 1'b0);
      end
      $display("test registers done");
      // On/off mode from stored values: on 5 units, off 3 units.
      apb(1'b1, DLT_CTRL_OFS, 32'h00000000);
      apb(1'b1, DLT_ON_INIT_OFS, 32'h00000005);
      apb(1'b1, DLT_OFF_INIT_OFS, 32'h00000003);
      trig(1'b1);
      cyc(15);
      out_is(1'b0, "on delay early");
      cyc(15);
      out_is(1'b1, "on delay end");
      trig(1'b0);
      cyc(6);
      trig(1'b1);
      out_is(1'b1, "short dropout");
      cyc(20);
      out_is(1'b1, "after dropout");
      trig(1'b0);
      cyc(8);
      out_is(1'b1, "off delay early");
      cyc(12);
      out_is(1'b0, "off delay end");
      trig(1'b1);
      cyc(12);
      trig(1'b0);
      cyc(30);
      out_is(1'b0, "short pulse");
      // Time inputs take over from the stored values.
      apb(1'b1, DLT_CTRL_OFS, 32'h00000030);
      dlt_far_model_inst.set_times(16'h0002, 16'h0001);
      trig(1'b1);
      cyc(14);
      out_is(1'b1, "rise from input");
      trig(1'b0);
      cyc(10);
      out_is(1'b0, "fall from input");
      dlt_far_model_inst.set_times(16'h0000, 16'h0000);
      trig(1'b1);
      cyc(3);
      out_is(1'b1, "zero rise delay");
      trig(1'b0);
      cyc(3);
      out_is(1'b0, "zero fall delay");
      $display("test on_off done");
      // Retentive mode: latch, hold and edge-only clear.
      apb(1'b1, DLT_CTRL_OFS, 32'h00000001);
      apb(1'b1, DLT_ON_INIT_OFS, 32'h00000003);
      trig(1'b1);
      cyc(20);
      out_is(1'b1, "retain set");
      rd_chk(DLT_STATUS_OFS, 32'h00000003, 1'b0);
      trig(1'b0);
      cyc(30);
      out_is(1'b1, "retain hold");
      dlt_far_model_inst.set_clear(1'b1);
      cyc(3);
      out_is(1'b0, "clear edge");
      trig(1'b1);
      cyc(20);
      out_is(1'b1, "clear level ignored");
      trig(1'b0);
      dlt_far_model_inst.set_clear(1'b0);
      apb(1'b1, DLT_CTRL_OFS, 32'h00000011);
      dlt_far_model_inst.set_clear(1'b1);
      cyc(3);
      out_is(1'b0, "second clear edge");
      dlt_far_model_inst.set_clear(1'b0);
      dlt_far_model_inst.set_times(16'h0001, 16'h0000);
      trig(1'b1);
      cyc(9);
      out_is(1'b1, "retain from input");
      trig(1'b0);
      dlt_far_model_inst.set_clear(1'b1);
      dlt_far_model_inst.set_clear(1'b0);
      $display("test retentive done");
      // Off-delay mode in units of ms, then 3 s.
      apb(1'b1, DLT_CTRL_OFS, 32'h00000002);
      cyc(3);
      trig(1'b1);
      cyc(3);
      out_is(1'b1, "off mode rise");
      trig(1'b0);
      cyc(8);
      out_is(1'b1, "off mode early");
      cyc(12);
      out_is(1'b0, "off mode end");
      apb(1'b1, DLT_CTRL_OFS, 32'h00000006);
      trig(1'b1);
      cyc(3);
      out_is(1'b1, "seconds rise");
      trig(1'b0);
      cyc(11000);
      out_is(1'b1, "seconds early");
      cyc(1100);
      out_is(1'b0, "seconds end");
      $display("test off_delay done");
      // Relay pulse mode: stored duration, early drop, input duration.
      apb(1'b1, DLT_CTRL_OFS, 32'h00000003);
      apb(1'b1, DLT_ON_INIT_OFS, 32'h00000004);
      trig(1'b1);
      cyc(3);
      out_is(1'b1, "relay rise");
      cyc(8);
      out_is(1'b1, "relay hold");
      cyc(15);
      out_is(1'b0, "relay expire");
      trig(1'b0);
      trig(1'b1);
      cyc(5);
      trig(1'b0);
      cyc(3);
      out_is(1'b0, "relay early drop");
      apb(1'b1, DLT_CTRL_OFS, 32'h00000013);
      trig(1'b1);
      cyc(3);
      out_is(1'b1, "relay input rise");
      cyc(8);
      out_is(1'b0, "relay input expire");
      trig(1'b0);
      $display("test relay done");
      close_out();
   end
endmodule : dlt_timer_test
`default_nettype wire
